// >>> common/oad_defines.svh
// Purpose: constants of the operand addressing and arithmetic decode block
// Assumes: customary encoding of the instruction set of this core
// Notes: included by the design files only
`ifndef OAD_DEFINES_SVH
`define OAD_DEFINES_SVH
`define OAD_SFR_BASE 8'h80
`define OAD_HI_ADD 4'h2
`define OAD_HI_ADD_CARRY 4'h3
`define OAD_HI_SUB_BORROW 4'h9
`define OAD_LO_IMMEDIATE 4'h4
`define OAD_LO_DIR 4'h5
`define OAD_LO_IND0 4'h6
`define OAD_LO_IND1 4'h7
`define OAD_OP_INC_DP 8'ha3
`define OAD_OP_MULTIPLY 8'ha4
`define OAD_OP_DIV 8'h84
`define OAD_OP_INC_A 8'h04
`define OAD_OP_MOVC_DP 8'h93
`define OAD_OP_MOVC_PC 8'h83
`define OAD_OP_JMP_IDX 8'h73
`define OAD_OP_PUSH 8'hc0
`define OAD_OP_XRD_DP 8'he0
`define OAD_OP_XWR_DP 8'hf0
`define OAD_OP_XRD_R0 8'he2
`define OAD_OP_XRD_R1 8'he3
`define OAD_OP_XWR_R0 8'hf2
`define OAD_OP_XWR_R1 8'hf3
`define OAD_CLK_CLASSIC 6'd12
`define OAD_CLK_REDUCED 6'd6
`define OAD_CLK_CLASSIC_2 6'd24
`define OAD_CLK_REDUCED_2 6'd12
`define OAD_CLK_CLASSIC_4 6'd48
`define OAD_CLK_REDUCED_4 6'd24
`endif

// >>> common/oad_pkg.sv
// Purpose: types of the operand addressing and arithmetic decode block
// Assumes: nothing beyond the defines header
// Notes: constants live in oad_defines.svh
package oad_pkg;
  typedef enum logic [2:0] {
    ModeNone, ModeImmediate, ModeDir, ModeIndirect, ModeReg, ModeRegSpec, ModeIdx
  } oad_mode_e;
  typedef enum logic [2:0] {SpNone, SpIramLow, SpSfr, SpIram, SpXram, SpCode} oad_space_e;
  typedef enum logic [1:0] {AluNone, AluAdd, AluAddCarry, AluSubBorrow} oad_alu_e;
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] byte1;
    logic [7:0] byte2;
  } oad_req_s;
  typedef struct packed {
    logic [7:0] acc;
    logic carry;
    logic [1:0] bank;
    logic [7:0] r0;
    logic [7:0] r1;
    logic [7:0] stackPointer;
    logic [15:0] dataPointer;
    logic [15:0] programCounter;
  } oad_core_s;
  typedef struct packed {
    oad_mode_e mode;
    oad_space_e space;
    logic [15:0] addr;
    logic [7:0] immediate;
    logic [2:0] regNum;
    logic [1:0] length;
    logic [5:0] clocks;
    logic writeOk;
    logic isJump;
    oad_alu_e aluOp;
    logic [7:0] sum;
    logic flagsValid;
    logic cy;
    logic ac;
    logic ov;
  } oad_res_s;
  typedef struct packed {
    logic valid;
    oad_res_s res;
  } oad_state_s;
endpackage

// >>> verilog/oad_arith.sv
// Purpose: accumulator add, add-carry and subtract-borrow with flags
// Assumes: purely combinational, caller registers the outputs
// Notes: flags follow the customary meaning of this core
`timescale 1ns/10ps
`include "oad_defines.svh"
module oad_arith
  import oad_pkg::*;
(
  // operation
  input wire oad_alu_e op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cyIn,
  // result
  output logic [7:0] sum,
  output logic cy,
  output logic ac,
  output logic ov
);
  logic [8:0] full;
  logic [4:0] low;
  logic cin;
  always_comb begin
    cin = (op == AluAdd) ? 1'b0 : cyIn;
    full = 9'h000;
    low = 5'h00;
    sum = a;
    cy = cyIn;
    ac = 1'b0;
    ov = 1'b0;
    if (op == AluAdd || op == AluAddCarry) begin
      full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      sum = full[7:0];
      cy = full[8];
      ac = low[4];
      ov = (a[7] == b[7]) && (full[7] != a[7]);
    end else if (op == AluSubBorrow) begin
      // borrow lands in bit 8 of the wrapped difference
      full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
      low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
      sum = full[7:0];
      cy = full[8];
      ac = low[4];
      ov = (a[7] != b[7]) && (full[7] != a[7]);
    end
  end
endmodule

// >>> verilog/oad_decode.sv
// Purpose: operand address resolution and arithmetic decode of one instruction
// Assumes: request bytes and core state are valid in the cycle reqValid is high
// Notes: answer one cycle after the request; operand data from memory arrives with the request
`timescale 1ns/10ps
`include "oad_defines.svh"
module oad_decode
  import oad_pkg::*;
#(
  parameter int CLK_W = 6
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // request
  input wire logic reqValid,
  input wire oad_req_s req,
  input wire logic [7:0] opData,
  input wire oad_core_s core,
  input wire logic reducedClockMode,
  // answer
  output logic resValid,
  output oad_res_s res
);
  // counts are held in six-bit fields of the result struct
  if (CLK_W != 6) begin : g_clkWidthCheck
    $error("oad_decode: clock count field must be 6 bits");
  end

  oad_state_s st_q;
  oad_state_s st_d;
  oad_res_s r;
  logic [3:0] hi;
  logic [3:0] lo;
  logic [5:0] clk1;
  logic [5:0] clk2;
  logic [5:0] clk4;
  logic [7:0] aluB;
  logic [7:0] aluSum;
  logic aluCy;
  logic aluAc;
  logic aluOv;

  assign hi = req.opcode[7:4];
  assign lo = req.opcode[3:0];
  assign clk1 = reducedClockMode ? `OAD_CLK_REDUCED : `OAD_CLK_CLASSIC;
  assign clk2 = reducedClockMode ? `OAD_CLK_REDUCED_2 : `OAD_CLK_CLASSIC_2;
  assign clk4 = reducedClockMode ? `OAD_CLK_REDUCED_4 : `OAD_CLK_CLASSIC_4;
  assign aluB = (r.mode == ModeImmediate) ? req.byte1 : opData;

  oad_arith u_arith (
    .op(r.aluOp),
    .a(core.acc),
    .b(aluB),
    .cyIn(core.carry),
    .sum(aluSum),
    .cy(aluCy),
    .ac(aluAc),
    .ov(aluOv)
  );

  always_comb begin
    r = '0;
    r.mode = ModeNone;
    r.space = SpNone;
    r.aluOp = AluNone;
    r.length = 2'd1;
    r.clocks = clk1;
    if ((hi == `OAD_HI_ADD || hi == `OAD_HI_ADD_CARRY || hi == `OAD_HI_SUB_BORROW) && lo >= `OAD_LO_IMMEDIATE) begin
      r.aluOp = (hi == `OAD_HI_ADD) ? AluAdd : ((hi == `OAD_HI_ADD_CARRY) ? AluAddCarry : AluSubBorrow);
      r.clocks = clk1;
      if (lo == `OAD_LO_IMMEDIATE) begin
        r.mode = ModeImmediate;
        r.space = SpCode;
        r.addr = core.programCounter + 16'h0001;
        r.immediate = req.byte1;
        r.length = 2'd2;
      end else if (lo == `OAD_LO_DIR) begin
        r.mode = ModeDir;
        r.addr = {8'h00, req.byte1};
        r.space = (req.byte1 >= `OAD_SFR_BASE) ? SpSfr : SpIramLow;
        r.length = 2'd2;
      end else if (lo == `OAD_LO_IND0 || lo == `OAD_LO_IND1) begin
        r.mode = ModeIndirect;
        r.space = SpIram;
        r.addr = {8'h00, req.opcode[0] ? core.r1 : core.r0};
      end else begin
        r.mode = ModeReg;
        r.space = SpIramLow;
        r.regNum = req.opcode[2:0];
        r.addr = {11'h000, core.bank, req.opcode[2:0]};
      end
    end else begin
      case (req.opcode)
        `OAD_OP_INC_DP: begin
          r.mode = ModeRegSpec;
          r.clocks = clk2;
        end
        `OAD_OP_MULTIPLY, `OAD_OP_DIV: begin
          r.mode = ModeRegSpec;
          r.clocks = clk4;
        end
        `OAD_OP_INC_A: begin
          r.mode = ModeRegSpec;
        end
        `OAD_OP_MOVC_DP, `OAD_OP_MOVC_PC: begin
          r.mode = ModeIdx;
          r.space = SpCode;
          r.clocks = clk2;
          r.addr = (req.opcode == `OAD_OP_MOVC_DP ? core.dataPointer : core.programCounter + 16'h0001)
                   + {8'h00, core.acc};
        end
        `OAD_OP_JMP_IDX: begin
          r.mode = ModeIdx;
          r.space = SpCode;
          r.isJump = 1'b1;
          r.clocks = clk2;
          r.addr = core.dataPointer + {8'h00, core.acc};
        end
        `OAD_OP_PUSH: begin
          r.mode = ModeIndirect;
          r.space = SpIram;
          r.writeOk = 1'b1;
          r.length = 2'd2;
          r.clocks = clk2;
          r.addr = {8'h00, core.stackPointer + 8'h01};
        end
        `OAD_OP_XRD_DP, `OAD_OP_XWR_DP: begin
          r.mode = ModeIndirect;
          r.space = SpXram;
          r.writeOk = (req.opcode == `OAD_OP_XWR_DP);
          r.clocks = clk2;
          r.addr = core.dataPointer;
        end
        `OAD_OP_XRD_R0, `OAD_OP_XRD_R1, `OAD_OP_XWR_R0, `OAD_OP_XWR_R1: begin
          r.mode = ModeIndirect;
          r.space = SpXram;
          r.writeOk = req.opcode[4];
          r.clocks = clk2;
          r.addr = {8'h00, req.opcode[0] ? core.r1 : core.r0};
        end
        default: begin
          r.mode = ModeNone;
        end
      endcase
    end
  end

  always_comb begin
    st_d = st_q;
    st_d.valid = reqValid;
    if (reqValid) begin
      st_d.res = r;
      st_d.res.sum = aluSum;
      st_d.res.cy = aluCy;
      st_d.res.ac = aluAc;
      st_d.res.ov = aluOv;
      st_d.res.flagsValid = (r.aluOp != AluNone);
    end
  end

  // holds last answer while idle so the partner can sample late
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign resValid = st_q.valid;
  assign res = st_q.res;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_dirAddr;
    reqValid && req.opcode[3:0] == `OAD_LO_DIR && req.opcode[7:4] == `OAD_HI_ADD
      |=> res.mode == ModeDir && res.addr == {8'h00, $past(req.byte1)};
  endproperty
  a_dirAddr: assert property (p_dirAddr) else $error("direct address not taken from byte after opcode");

  property p_dirSpace;
    resValid && res.mode == ModeDir |-> (res.addr[7] ? res.space == SpSfr : res.space == SpIramLow);
  endproperty
  a_dirSpace: assert property (p_dirSpace) else $error("direct access left low ram and special registers");

  property p_indSmall;
    resValid && res.mode == ModeIndirect && res.space == SpIram |-> res.addr[15:8] == 8'h00;
  endproperty
  a_indSmall: assert property (p_indSmall) else $error("byte pointer produced a wide address");

  property p_indWide;
    reqValid && (req.opcode == `OAD_OP_XRD_DP || req.opcode == `OAD_OP_XWR_DP)
      |=> res.space == SpXram && res.addr == $past(core.dataPointer);
  endproperty
  a_indWide: assert property (p_indWide) else $error("wide indirect address not from data pointer");

  property p_regMode;
    resValid && res.mode == ModeReg |-> res.length == 2'd1 && res.addr[2:0] == res.regNum;
  endproperty
  a_regMode: assert property (p_regMode) else $error("register mode length or number wrong");

  property p_codeReadOnly;
    resValid && res.space == SpCode |-> !res.writeOk;
  endproperty
  a_codeReadOnly: assert property (p_codeReadOnly) else $error("program memory access allows a write");

  property p_jumpSum;
    reqValid && req.opcode == `OAD_OP_JMP_IDX
      |=> res.isJump && res.addr == $past(core.dataPointer) + {8'h00, $past(core.acc)};
  endproperty
  a_jumpSum: assert property (p_jumpSum) else $error("indexed jump target is not base plus accumulator");

  property p_addLen;
    resValid && (res.aluOp == AluAdd || res.aluOp == AluAddCarry)
      |-> res.length == ((res.mode == ModeDir || res.mode == ModeImmediate) ? 2'd2 : 2'd1);
  endproperty
  a_addLen: assert property (p_addLen) else $error("add group byte length wrong");

  property p_arithClk;
    reqValid && reducedClockMode && (req.opcode[7:4] == `OAD_HI_SUB_BORROW) && req.opcode[3:0] >= `OAD_LO_IMMEDIATE
      |=> res.aluOp == AluSubBorrow && res.clocks == 6'd6;
  endproperty
  a_arithClk: assert property (p_arithClk) else $error("subtract borrow not 6 clocks in reduced mode");

  property p_longClk;
    reqValid && reducedClockMode && req.opcode == `OAD_OP_MULTIPLY |=> res.clocks == 6'd24;
  endproperty
  a_longClk: assert property (p_longClk) else $error("multiply not 24 clocks in reduced mode");

  property p_addFlags;
    reqValid && req.opcode == 8'h24
      |=> {res.cy, res.sum} == {1'b0, $past(core.acc)} + {1'b0, $past(req.byte1)} && res.flagsValid;
  endproperty
  a_addFlags: assert property (p_addFlags) else $error("immediate add carry or sum wrong");
endmodule

// >>> verif/oad_mem_model.sv
// Purpose: internal data memory beside the decode block
// Assumes: operand byte must be ready in the cycle of the request
// Notes: immediate requests get a useless inverted byte, so a decoder using it shows up
`timescale 1ns/10ps
module oad_mem_model
  import oad_pkg::*;
(
  // request seen by the core
  input wire oad_req_s req,
  input wire oad_core_s core,
  // operand byte
  output logic [7:0] opData
);
  logic [7:0] iram [256];

  initial begin
    for (int i = 0; i < 256; i++) begin
      iram[i] = 8'(i) ^ 8'h5a;
    end
  end

  always_comb begin
    case (req.opcode[3:0])
      4'h5: opData = iram[req.byte1];
      4'h6: opData = iram[core.r0];
      4'h7: opData = iram[core.r1];
      4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf: opData = iram[{3'b000, core.bank, req.opcode[2:0]}];
      default: opData = ~req.byte1;
    endcase
  end
endmodule

// >>> verif/tb_operand_addressing_arith_decode.sv
// Purpose: self-checking bench of the decode block
// Assumes: answer one cycle after each taken request
// Notes: inputs change at the falling edge only
`timescale 1ns/10ps
module tb_operand_addressing_arith_decode;
  import oad_pkg::*;
  logic core_clk, rst_n, reqValid, reducedClockMode, resValid;
  logic [7:0] opData;
  oad_req_s req;
  oad_core_s core;
  oad_res_s res;
  int miscompares = 0;
  int num_checks = 0;

  oad_decode i_dut(.core_clk(core_clk), .rst_n(rst_n), .reqValid(reqValid), .req(req), .opData(opData),
    .core(core), .reducedClockMode(reducedClockMode), .resValid(resValid), .res(res));
  oad_mem_model i_mem(.req(req), .core(core), .opData(opData));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  function automatic logic [7:0] mb(input logic [7:0] a);
    return a ^ 8'h5a;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic run(input logic [7:0] op, input logic [7:0] b1);
    @(negedge core_clk);
    reqValid = 1'b1;
    req = '{opcode: op, byte1: b1, byte2: 8'h00};
    @(negedge core_clk);
    reqValid = 1'b0;
    check(resValid, 1'b1);
  endtask

  task automatic t_arith;
    logic [7:0] op, src;
    logic [8:0] s;
    for (int m = 0; m < 2; m++) begin
      for (int h = 0; h < 3; h++) begin
        for (int l = 4; l < 16; l++) begin
          reducedClockMode = m[0];
          op = {h == 0 ? 4'h2 : h == 1 ? 4'h3 : 4'h9, 4'(l)};
          src = l == 4 ? 8'h25 : mb(l == 5 ? 8'h25 : l == 6 ? core.r0 : l == 7 ? core.r1 :
            {3'b000, core.bank, op[2:0]});
          run(op, 8'h25);
          s = h == 2 ? core.acc - src - core.carry : core.acc + src + (h == 1 ? core.carry : 1'b0);
          check(res.sum, s[7:0]);
          check(res.flagsValid, 1'b1);
          check(res.aluOp, h == 0 ? AluAdd : h == 1 ? AluAddCarry : AluSubBorrow);
          check(res.clocks, m ? 6'd6 : 6'd12);
          check(res.length, l < 6 ? 2'd2 : 2'd1);
          check(res.mode, l == 4 ? ModeImmediate : l == 5 ? ModeDir : l < 8 ? ModeIndirect : ModeReg);
          check(res.addr, l == 4 ? core.programCounter + 16'h1 : l == 5 ? 16'h0025 : l == 6 ? {8'h00, core.r0} :
            l == 7 ? {8'h00, core.r1} : {11'h0, core.bank, op[2:0]});
          check(res.space, l == 4 ? SpCode : l < 6 ? SpIramLow : l < 8 ? SpIram : SpIramLow);
          if (l == 4) check(res.immediate, 8'h25);
          if (l > 7) check(res.regNum, op[2:0]);
        end
      end
    end
    $display("test arith done");
  endtask

  task automatic t_flags;
    logic [7:0] ops[3] = '{8'h24, 8'h94, 8'h34};
    logic [7:0] acc[3] = '{8'h7f, 8'h00, 8'hff};
    logic [7:0] immediate_mode[3] = '{8'h01, 8'h01, 8'h00};
    logic [7:0] sum[3] = '{8'h80, 8'hff, 8'h00};
    logic [2:0] fl[3] = '{3'b011, 3'b110, 3'b110};
    for (int i = 0; i < 3; i++) begin
      core.acc = acc[i];
      core.carry = i == 2;
      run(ops[i], immediate_mode[i]);
      check(res.sum, sum[i]);
      check({res.cy, res.ac, res.ov}, fl[i]);
    end
    $display("test flags done");
  endtask

  task automatic t_direct;
    logic [7:0] a[3] = '{8'h7f, 8'h80, 8'h90};
    for (int i = 0; i < 3; i++) begin
      run(8'h25, a[i]);
      check(res.addr, {8'h00, a[i]});
      check(res.space, i == 0 ? SpIramLow : SpSfr);
    end
    @(negedge core_clk);
    check(resValid, 1'b0);
    check(res.addr, 16'h0090);
    $display("test direct done");
  endtask

  task automatic t_regspec;
    logic [7:0] ops[4] = '{8'ha3, 8'ha4, 8'h84, 8'h04};
    logic [5:0] clk[4] = '{6'd12, 6'd24, 6'd24, 6'd6};
    reducedClockMode = 1'b1;
    for (int i = 0; i < 4; i++) begin
      run(ops[i], 8'h11);
      check(res.mode, ModeRegSpec);
      check(res.length, 2'd1);
      check(res.clocks, clk[i]);
    end
    $display("test register specific done");
  endtask

  task automatic t_index;
    logic [7:0] ops[3] = '{8'h93, 8'h83, 8'h73};
    core.acc = 8'hf0;
    for (int i = 0; i < 3; i++) begin
      run(ops[i], 8'h00);
      check(res.addr, (i == 1 ? core.programCounter + 16'h1 : core.dataPointer) + 16'h00f0);
      check({res.mode, res.space, res.writeOk}, {ModeIdx, SpCode, 1'b0});
      check(res.isJump, i == 2);
    end
    $display("test indexed done");
  endtask

  task automatic t_indirect;
    logic [7:0] ops[5] = '{8'he0, 8'hf0, 8'he2, 8'hf3, 8'hc0};
    logic [15:0] ad[5];
    ad = '{core.dataPointer, core.dataPointer, {8'h00, core.r0}, {8'h00, core.r1}, {8'h00, core.stackPointer + 8'h1}};
    for (int i = 0; i < 5; i++) begin
      run(ops[i], 8'h00);
      check(res.addr, ad[i]);
      check(res.space, i == 4 ? SpIram : SpXram);
      check(res.writeOk, i % 2 == 1 || i == 4);
    end
    $display("test indirect done");
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // watchdog, about sixteen times the expected run
  initial begin
    #(3000 * 100);
    miscompares++;
    conclude();
  end

  initial begin
    rst_n = 1'b0;
    reqValid = 1'b0;
    reducedClockMode = 1'b1;
    req = '0;
    core = '{acc: 8'h3c, carry: 1'b1, bank: 2'h2, r0: 8'h31, r1: 8'hc4, stackPointer: 8'h07,
      dataPointer: 16'h1220, programCounter: 16'h0100};
    repeat (5) @(negedge core_clk);
    check(resValid, 1'b0);
    check({res.mode, res.space}, {ModeNone, SpNone});
    rst_n = 1'b1;
    t_arith();
    t_direct();
    t_regspec();
    t_index();
    t_indirect();
    t_flags();
    conclude();
  end
endmodule
